/* File: bench/sfc_ctrl_tb_top.sv */
// Self-checking bench of the serial flash host controller
`timescale 1ns/1ps
module sfc_ctrl_tb_top import sfc_pkg::*;;
   // Arbitrary identification values
   localparam logic [7:0] MK = 8'h5e;
   localparam logic [7:0] PT = 8'h6a;
   logic aclk, aresetn, miso;
   sfc_axi_req_s req;
   sfc_axi_rsp_s rsp;
   sfc_spi_s spi;
   logic [31:0] st, v;
   logic [1:0] r;
   int mismatches, n_checks;
   sfc_ctrl u_sfc_ctrl (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .spi_out(spi), .spi_miso(miso));
   sfc_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT)) u_sfc_flash_model (.cs_n(spi.cs_n),
      .sck(spi.sck), .mosi(spi.mosi), .miso(miso));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ah, wh, b, at, wt;
      {b, at, wt} = 3'b000;
      @(posedge aclk);
      req.awaddr <= {24'h0, a};
      req.wdata <= d;
      req.wstrb <= 4'hf;
      {req.awvalid, req.wvalid, req.bready} <= 3'b111;
      // No cycle limit: only the watchdog ends a stuck wait
      while (!b) begin
         @(negedge aclk);
         ah = req.awvalid && rsp.awready;
         wh = req.wvalid && rsp.wready;
         b = rsp.bvalid === 1'b1;
         if (b) chk(rsp.bresp, er, "write response");
         if (b) chk({at, wt}, 2'b11, "write taken");
         at = at || ah;
         wt = wt || wh;
         @(posedge aclk);
         if (ah) req.awvalid <= 1'b0;
         if (wh) req.wvalid <= 1'b0;
         if (b) req.bready <= 1'b0;
      end
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      logic ah, b, at;
      {b, at} = 2'b00;
      @(posedge aclk);
      req.araddr <= {24'h0, a};
      {req.arvalid, req.rready} <= 2'b11;
      while (!b) begin
         @(negedge aclk);
         ah = req.arvalid && rsp.arready;
         b = rsp.rvalid === 1'b1;
         d = rsp.rdata;
         rs = rsp.rresp;
         if (b) chk(at, 1'b1, "read taken");
         at = at || ah;
         @(posedge aclk);
         if (ah) req.arvalid <= 1'b0;
         if (b) req.rready <= 1'b0;
      end
   endtask : axr
   task automatic pollb;
      st = 32'h1;
      for (int t = 0; t < 3000 && st[0] === 1'b1; t++) axr(SFC_REG_STATUS, st, r);
      chk(st[0], 1'b0, "busy clears");
   endtask : pollb
   task automatic fl(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
         input logic [4:0] n, input logic c);
      axw(SFC_REG_ADDR, {8'h0, a}, SFC_RESP_OKAY);
      axw(SFC_REG_WDATA, {24'h0, d}, SFC_RESP_OKAY);
      axw(SFC_REG_CMD, {15'h0, c, 3'h0, n, op}, SFC_RESP_OKAY);
      pollb;
   endtask : fl
   task automatic bufchk(input logic [3:0] i, input logic [7:0] e);
      axr(8'h40 + {2'b00, i, 2'b00}, v, r);
      chk(v[7:0], e, "buffer byte");
   endtask : bufchk
   // ==========================================
   // Scenarios
   task automatic t_prot;
      chk(spi.cs_n, 1'b1, "idle select");
      fl(8'h02, 24'h123, 8'h5a, 0, 0);
      chk(st[15:8], 8'h0e, "dropped program");
      fl(8'h03, 24'h123, 8'h00, 1, 0);
      bufchk(0, 8'hff);
      fl(8'h01, 24'h0, 8'h00, 0, 0);
      chk(u_sfc_flash_model.bp, 2'b00, "status write");
      $display("protect done");
   endtask : t_prot
   task automatic t_prog;
      fl(8'h02, 24'h123, 8'h5a, 0, 0);
      chk(st[15:0], 16'h0000, "program status");
      fl(8'h03, 24'h123, 8'h00, 1, 0);
      chk(st[20:16], 5'd1, "byte count");
      bufchk(0, 8'h5a);
      fl(8'h02, 24'h123, 8'h33, 0, 0);
      chk(st[1], 1'b1, "erased check");
      u_sfc_flash_model.mem[32'h7ffff] = 8'h3c;
      u_sfc_flash_model.mem[0] = 8'hc3;
      fl(8'h03, 24'hf7ffff, 8'h00, 3, 0);
      bufchk(0, 8'h3c);
      bufchk(1, 8'hc3);
      bufchk(2, 8'hff);
      $display("program done");
   endtask : t_prog
   task automatic t_id_aai;
      fl(8'h90, 24'h1, 8'h00, 2, 0);
      bufchk(0, PT);
      bufchk(1, MK);
      fl(8'hab, 24'h0, 8'h00, 1, 0);
      bufchk(0, MK);
      fl(8'haf, 24'h200, 8'h11, 0, 0);
      chk(st[15:8], 8'h42, "auto mode");
      fl(8'haf, 24'h0, 8'h22, 0, 1);
      fl(8'h04, 24'h0, 8'h00, 0, 0);
      fl(8'h03, 24'h200, 8'h00, 2, 0);
      bufchk(0, 8'h11);
      bufchk(1, 8'h22);
      chk(u_sfc_flash_model.write_enable_latch, 1'b0, "lock frame");
      $display("ident and auto done");
   endtask : t_id_aai
   task automatic t_erase;
      logic [7:0] ops [3] = '{8'h20, 8'h52, 8'h60};
      logic [23:0] ea [3] = '{24'h01fff, 24'h17fff, 24'h0};
      logic [23:0] ca [3] = '{24'h01000, 24'h10000, 24'h55555};
      for (int i = 0; i < 3; i++) begin
         u_sfc_flash_model.mem[ca[i]] = 8'h00;
         fl(ops[i], ea[i], 8'h00, 0, 0);
         fl(8'h03, ca[i], 8'h00, 1, 0);
         bufchk(0, 8'hff);
      end
      $display("erase done");
   endtask : t_erase
   task automatic t_bus;
      axr(8'h10, v, r);
      chk(r, SFC_RESP_SLVERR, "unmapped");
      chk(v, 32'h0, "unmapped data");
      axw(SFC_REG_STATUS, 32'h1, SFC_RESP_SLVERR);
      axw(SFC_REG_ADDR, 32'h00abcdef, SFC_RESP_OKAY);
      axr(SFC_REG_ADDR, v, r);
      chk(v[23:0], 24'habcdef, "address reg");
      axw(SFC_REG_CMD, {24'h0, SFC_OP_WRITE_UNLOCK_CMD}, SFC_RESP_OKAY);
      axw(SFC_REG_CMD, {24'h0, SFC_OP_WRITE_LOCK_CMD}, SFC_RESP_SLVERR);
      pollb;
      chk(u_sfc_flash_model.write_enable_latch, 1'b1, "unlock only");
      fl(SFC_OP_STATUS_READ_CMD, 24'h0, 8'h00, 2, 0);
      bufchk(0, 8'h02);
      bufchk(1, 8'h02);
      $display("bus done");
   endtask : t_bus
   // ==========================================
   initial begin
      req = '0;
      aresetn = 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_prot;
      t_prog;
      t_id_aai;
      t_erase;
      t_bus;
      results;
   end
   // Run needs roughly 75 us
   initial begin
      #380000;
      mismatches++;
      results;
   end
endmodule : sfc_ctrl_tb_top

/* File: bench/sfc_flash_model.sv */
// Behavioural serial flash partner for the host controller bench
`timescale 1ns/1ps
module sfc_flash_model #(
   // Arbitrary identification values
   parameter logic [7:0] MAKER_CODE = 8'h11,
   parameter logic [7:0] PART_CODE = 8'h22
) (
   // Flash pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso
);
   logic [7:0] mem [int];
   logic [7:0] sh, op, dat, ob;
   logic [18:0] ad, pa;
   logic [1:0] bp = 2'b11;
   logic write_enable_latch = 1'b0, busy = 1'b0, arm = 1'b0, auto_increment_program = 1'b0;
   int nb, nbit, obit, sz;
   function automatic logic [7:0] rd(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction : rd
   // protected fraction counted from the top
   function automatic logic prot(input logic [18:0] a);
      return bp == 2'b11 || bp == 2'b10 && a[18] || bp == 2'b01 && a[18:17] == 2'b11;
   endfunction : prot
   // busy while self-timed, then latch drops unless in auto-increment mode
   task go;
      busy = 1'b1;
      fork
         begin
            #2000;
            busy = 1'b0;
            if (!auto_increment_program) write_enable_latch = 1'b0;
         end
      join_none
   endtask : go
   // ==========================================
   // Serial framing
   initial miso = 1'b0;
   always @(negedge cs_n) begin
      nb = 0;
      nbit = 0;
      obit = 0;
   end
   // eight bits a cycle, MSB first, top bits dropped
   always @(posedge sck) if (!cs_n) begin
      sh = {sh[6:0], mosi};
      nbit = (nbit + 1) % 8;
      if (nbit == 0) begin
         if (nb == 0) op = sh;
         else if (nb < 4 && op != 8'h01 && !(op == 8'haf && auto_increment_program)) ad = {ad[10:0], sh};
         else dat = sh;
         nb++;
      end
   end
   always @(negedge sck) if (!cs_n) begin
      if (nb >= 4 && (op == 8'h03 || op == 8'h90 || op == 8'hab) || nb >= 1 && op == 8'h05) begin
         if (obit == 0) begin
            ob = op == 8'h05 ? {1'b0, auto_increment_program, 2'b00, bp, write_enable_latch, busy} :
               op == 8'h03 ? rd(ad) : ad[0] ? PART_CODE : MAKER_CODE;
            if (op != 8'h05) ad = ad + 1'b1;
         end
         miso = ob[3'(7 - obit)];
         obit = (obit + 1) % 8;
      end else miso = ~miso;
   end
   // ==========================================
   // act on whole cycles at select rise, idle only
   always @(posedge cs_n) if (nbit == 0 && !busy) begin
      case (op)
         8'h06: write_enable_latch = 1'b1;
         8'h04: {write_enable_latch, auto_increment_program} = 2'b00;
         // status write only straight after arming
         8'h01: if (arm && nb == 2) bp = dat[3:2];
         8'h02, 8'haf: if (write_enable_latch && (nb == 5 || auto_increment_program && nb == 2 && op == 8'haf)) begin
            pa = nb == 5 ? ad : pa + 1'b1;
            auto_increment_program = op == 8'haf;
            if (!prot(pa)) begin
               mem[pa] = rd(pa) & dat;
               go;
            end
         end
         8'h20, 8'h52: if (write_enable_latch && !prot(ad)) begin
            sz = op == 8'h20 ? 4096 : 32768;
            for (int i = 0; i < sz; i++) mem.delete((int'(ad) & ~(sz - 1)) + i);
            go;
         end
         8'h60: if (write_enable_latch && bp == 2'b00) begin
            mem.delete();
            go;
         end
         default: ;
      endcase
      arm = op == 8'h50 && nb == 1;
   end
endmodule : sfc_flash_model

/* File: core/sfc_ctrl.sv */
// Serial flash host controller: AXI4-Lite registers to flash instruction frames
//
// Contract
// - Every bus cycle is eight clocks
// - Read: 03H, three address bytes, then data
// - Host holds select low for whole read
// - Single-byte instructions: 60H, 06H, 04H, 50H
// - Host sends write enable before writes
// - Host programs only erased bytes; code checks byte program and first AFH byte, not AFH continuations
// - Operation starts when select rises after instruction
// - Host polls busy before next write
// - Auto-increment: AFH, address, data; then AFH, data
// - Status write directly follows arm opcode
// - Frame starts at select fall, MSB first
`timescale 1ns/1ps
module sfc_ctrl
   import sfc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire sfc_axi_req_s axi_req,
   output sfc_axi_rsp_s axi_rsp,
   // Flash pins
   output sfc_spi_s spi_out,
   input wire logic spi_miso
);

   typedef struct packed {
      sfc_step_e step;
      sfc_ph_e ph;
      logic [3:0] cnt;
      logic [2:0] bitc;
      logic [4:0] bi;
      logic [7:0] sh_o;
      logic [7:0] sh_i;
      logic cs_n;
      logic sck;
      logic mosi;
      logic sync1;
      logic sync2;
      logic [7:0] op;
      logic [4:0] nrx;
      logic cont;
      logic [23:0] addr;
      logic [7:0] wdat;
      logic err;
      logic chk_ff;
      logic [7:0] fstat;
      logic [4:0] rxn;
      logic aw_h;
      logic [7:0] awa;
      logic w_h;
      logic [31:0] wd;
      logic [3:0] ws;
      logic awrdy;
      logic wrdy;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_h;
      logic [7:0] ara;
      logic rw;
      logic arrdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sfc_st_s;

   sfc_st_s st_r, st_nxt;

   logic [7:0] f_op, tx_nb, mem_rd, nop;
   logic f_adr, f_dat, f_id, f_poll, last, rx_phase, chk, wen;
   logic [4:0] f_nrx, f_ntx, nb, rxi, nn;
   logic mem_we;
   logic [31:0] mask;
   sfc_step_e first;

   function automatic logic is_wr(input logic [7:0] o);
      return o inside {SFC_OP_BYTE_PROGRAM, SFC_OP_AUTO_INCREMENT_PROGRAM,
                       SFC_OP_SECTOR_ERASE, SFC_OP_BLOCK_ERASE, SFC_OP_CHIP_ERASE};
   endfunction : is_wr

   function automatic logic is_id(input logic [7:0] o);
      return o inside {SFC_OP_IDENT_A, SFC_OP_IDENT_B};
   endfunction : is_id

   // ==========================================================
   // Receive buffer
   sfc_rxbuf u_rxbuf (
      .aclk(aclk),
      .we(mem_we),
      .waddr(rxi[SFC_RX_AW-1:0]),
      .wdata(st_r.sh_i),
      .raddr(st_r.ara[SFC_RX_AW+1:2]),
      .rdata(mem_rd)
   );

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      mem_we = 1'b0;
      last = 1'b0;
      // Two flops before anything looks at the returning data
      st_nxt.sync1 = spi_miso;
      st_nxt.sync2 = st_r.sync1;

      f_id = 1'b0;
      f_poll = 1'b0;
      f_adr = 1'b0;
      f_dat = 1'b0;
      f_nrx = 5'd0;
      f_op = st_r.op;
      case (st_r.step)
         SQ_CHK: begin
            f_op = SFC_OP_READ;
            f_adr = 1'b1;
            f_nrx = 5'd1;
         end
         SQ_ARM: f_op = SFC_OP_STATUS_WRITE_ARM_CMD;
         SQ_WEN: f_op = SFC_OP_WRITE_UNLOCK_CMD;
         SQ_POLL: begin
            f_op = SFC_OP_STATUS_READ_CMD;
            f_poll = 1'b1;
         end
         default: begin
            f_adr = st_r.op inside {SFC_OP_READ, SFC_OP_SECTOR_ERASE, SFC_OP_BLOCK_ERASE,
                                    SFC_OP_BYTE_PROGRAM} || is_id(st_r.op)
                    || (st_r.op == SFC_OP_AUTO_INCREMENT_PROGRAM && !st_r.cont);
            f_id = is_id(st_r.op);
            f_dat = st_r.op inside {SFC_OP_BYTE_PROGRAM, SFC_OP_AUTO_INCREMENT_PROGRAM,
                                    SFC_OP_STATUS_WRITE_CMD};
            if (st_r.op inside {SFC_OP_READ, SFC_OP_STATUS_READ_CMD} || f_id) begin
               f_nrx = st_r.nrx;
            end
         end
      endcase
      f_ntx = 5'd1 + (f_adr ? 5'd3 : 5'd0) + (f_dat ? 5'd1 : 5'd0);
      nb = st_r.bi + 5'd1;
      rxi = st_r.bi - f_ntx;
      rx_phase = (st_r.bi >= f_ntx);

      tx_nb = 8'h00;
      if (f_adr && nb <= 5'd3) begin
         // two zero bytes, then the ident address
         if (f_id) begin
            tx_nb = (nb == 5'd3) ? st_r.addr[7:0] : 8'h00;
         end else begin
            case (nb)
               5'd1: tx_nb = st_r.addr[23:16];
               5'd2: tx_nb = st_r.addr[15:8];
               default: tx_nb = st_r.addr[7:0];
            endcase
         end
      end else if (nb < f_ntx) begin
         tx_nb = st_r.wdat;
      end

      // ==========================================================
      // Frame engine
      case (st_r.ph)
         // select falls two half clocks before first rising edge
         PH_LEAD: begin
            st_nxt.cs_n = 1'b0;
            st_nxt.cnt = st_r.cnt + 4'd1;
            if (st_r.cnt == SFC_HALF_CYC - 4'd1) begin
               st_nxt.cnt = 4'd0;
               st_nxt.ph = PH_BIT;
               st_nxt.bitc = 3'd0;
               st_nxt.bi = 5'd0;
               st_nxt.sh_o = f_op;
               st_nxt.mosi = f_op[7];
            end
         end
         PH_BIT: begin
            st_nxt.cnt = st_r.cnt + 4'd1;
            if (st_r.cnt == SFC_HALF_CYC - 4'd1) begin
               st_nxt.cnt = 4'd0;
               if (!st_r.sck) begin
                  st_nxt.sck = 1'b1;
                  st_nxt.sh_i = {st_r.sh_i[6:0], st_r.sync2};
               end else begin
                  st_nxt.sck = 1'b0;
                  // byte closes after eighth falling edge
                  if (st_r.bitc == 3'd7) begin
                     if (f_poll) begin
                        if (rx_phase) begin
                           st_nxt.fstat = st_r.sh_i;
                           last = !st_r.sh_i[SFC_BUSY_BIT];
                        end
                     end else begin
                        // select stays low until every byte is in
                        last = (nb == f_ntx + f_nrx);
                        if (rx_phase && st_r.step == SQ_CHK) begin
                           st_nxt.chk_ff = (st_r.sh_i == SFC_ERASED_BYTE);
                        end else if (rx_phase) begin
                           mem_we = 1'b1;
                           st_nxt.rxn = st_r.rxn + 5'd1;
                        end
                     end
                     if (last) begin
                        st_nxt.ph = PH_TAIL;
                        st_nxt.mosi = 1'b0;
                     end else begin
                        // Long polls hold the index so it cannot wrap
                        st_nxt.bi = (f_poll && rx_phase) ? st_r.bi : nb;
                        st_nxt.bitc = 3'd0;
                        st_nxt.sh_o = tx_nb;
                        st_nxt.mosi = tx_nb[7];
                     end
                  end else begin
                     st_nxt.bitc = st_r.bitc + 3'd1;
                     st_nxt.sh_o = {st_r.sh_o[6:0], 1'b0};
                     st_nxt.mosi = st_r.sh_o[6];
                  end
               end
            end
         end
         // select rises only after the whole instruction
         PH_TAIL: begin
            st_nxt.cnt = st_r.cnt + 4'd1;
            if (st_r.cnt == SFC_HALF_CYC - 4'd1) begin
               st_nxt.cnt = 4'd0;
               st_nxt.cs_n = 1'b1;
               st_nxt.ph = PH_GAP;
            end
         end
         PH_GAP: begin
            st_nxt.cnt = st_r.cnt + 4'd1;
            if (st_r.cnt == SFC_GAP_CYC - 4'd1) begin
               st_nxt.cnt = 4'd0;
               st_nxt.ph = PH_LEAD;
               case (st_r.step)
                  SQ_CHK: begin
                     st_nxt.step = st_r.chk_ff ? SQ_WEN : SQ_IDLE;
                     st_nxt.err = !st_r.chk_ff;
                  end
                  // status write is the very next instruction
                  SQ_ARM: st_nxt.step = SQ_MAIN;
                  SQ_WEN: st_nxt.step = SQ_MAIN;
                  SQ_MAIN: st_nxt.step = is_wr(st_r.op) ? SQ_POLL : SQ_IDLE;
                  default: st_nxt.step = SQ_IDLE;
               endcase
               if (st_nxt.step == SQ_IDLE) begin
                  st_nxt.ph = PH_IDLE;
               end
            end
         end
         default: begin
            st_nxt.cs_n = 1'b1;
            st_nxt.sck = 1'b0;
         end
      endcase

      // ==========================================================
      // AXI4-Lite write
      if (st_r.bvalid && axi_req.bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.awrdy && axi_req.awvalid) begin
         st_nxt.aw_h = 1'b1;
         st_nxt.awa = axi_req.awaddr[7:0];
      end
      if (st_r.wrdy && axi_req.wvalid) begin
         st_nxt.w_h = 1'b1;
         st_nxt.wd = axi_req.wdata;
         st_nxt.ws = axi_req.wstrb;
      end
      mask = {{8{st_r.ws[3]}}, {8{st_r.ws[2]}}, {8{st_r.ws[1]}}, {8{st_r.ws[0]}}};
      nop = st_r.wd[7:0];
      nn = (st_r.wd[SFC_CMD_NRX_LSB +: 5] > SFC_RX_MAX) ? SFC_RX_MAX
                                                        : st_r.wd[SFC_CMD_NRX_LSB +: 5];
      chk = (nop == SFC_OP_BYTE_PROGRAM) || (nop == SFC_OP_AUTO_INCREMENT_PROGRAM
                                              && !st_r.wd[SFC_CMD_CONT_BIT]);
      wen = is_wr(nop) && !(nop == SFC_OP_AUTO_INCREMENT_PROGRAM && st_r.wd[SFC_CMD_CONT_BIT]);
      // writes except auto-increment continuations go through the unlock step
      first = chk ? SQ_CHK : (nop == SFC_OP_STATUS_WRITE_CMD) ? SQ_ARM : wen ? SQ_WEN : SQ_MAIN;
      if (st_r.aw_h && st_r.w_h && !st_r.bvalid) begin
         st_nxt.aw_h = 1'b0;
         st_nxt.w_h = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = SFC_RESP_OKAY;
         case (st_r.awa)
            SFC_REG_CMD: begin
               // Busy controller refuses a new command
               if (st_r.step == SQ_IDLE) begin
                  st_nxt.op = nop;
                  st_nxt.nrx = nn;
                  st_nxt.cont = st_r.wd[SFC_CMD_CONT_BIT];
                  st_nxt.err = 1'b0;
                  st_nxt.rxn = 5'd0;
                  st_nxt.step = first;
                  st_nxt.ph = PH_LEAD;
                  st_nxt.cnt = 4'd0;
               end else begin
                  st_nxt.bresp = SFC_RESP_SLVERR;
               end
            end
            SFC_REG_ADDR: st_nxt.addr = 24'((st_r.wd & mask) | ({8'h00, st_r.addr} & ~mask));
            SFC_REG_WDATA: st_nxt.wdat = 8'((st_r.wd & mask) | ({24'h0, st_r.wdat} & ~mask));
            default: st_nxt.bresp = SFC_RESP_SLVERR;
         endcase
      end
      st_nxt.awrdy = !st_nxt.aw_h && !st_nxt.bvalid;
      st_nxt.wrdy = !st_nxt.w_h && !st_nxt.bvalid;

      // ==========================================================
      // AXI4-Lite read: one wait cycle for the buffer
      if (st_r.rvalid && axi_req.rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (st_r.arrdy && axi_req.arvalid) begin
         st_nxt.ar_h = 1'b1;
         st_nxt.ara = axi_req.araddr[7:0];
         st_nxt.rw = 1'b0;
      end
      if (st_r.ar_h) begin
         st_nxt.rw = 1'b1;
         if (st_r.rw) begin
            st_nxt.ar_h = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = SFC_RESP_OKAY;
            st_nxt.rdata = 32'h0;
            case (st_r.ara)
               SFC_REG_CMD: st_nxt.rdata = {15'h0, st_r.cont, 3'h0, st_r.nrx, st_r.op};
               SFC_REG_ADDR: st_nxt.rdata = {8'h00, st_r.addr};
               SFC_REG_WDATA: st_nxt.rdata = {24'h0, st_r.wdat};
               SFC_REG_STATUS: begin
                  st_nxt.rdata[0] = (st_r.step != SQ_IDLE);
                  st_nxt.rdata[SFC_ST_ERR_BIT] = st_r.err;
                  st_nxt.rdata[SFC_ST_FSTAT_LSB +: 8] = st_r.fstat;
                  st_nxt.rdata[SFC_ST_RXN_LSB +: 5] = st_r.rxn;
               end
               default: begin
                  if (st_r.ara[7:6] == SFC_RXBUF_PAGE) begin
                     st_nxt.rdata = {24'h0, mem_rd};
                  end else begin
                     st_nxt.rresp = SFC_RESP_SLVERR;
                  end
               end
            endcase
         end
      end
      st_nxt.arrdy = !st_nxt.ar_h && !st_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.cs_n <= SFC_RST_CS_N;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign axi_rsp = '{awready: st_r.awrdy, wready: st_r.wrdy, bvalid: st_r.bvalid,
                      bresp: st_r.bresp, arready: st_r.arrdy, rvalid: st_r.rvalid,
                      rdata: st_r.rdata, rresp: st_r.rresp};
   assign spi_out = '{cs_n: st_r.cs_n, sck: st_r.sck, mosi: st_r.mosi};

   // ==========================================================
   // Checks
   logic [2:0] rise_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn || st_r.cs_n) begin
         rise_cnt <= 3'd0;
      end else if (st_nxt.sck && !st_r.sck) begin
         rise_cnt <= rise_cnt + 3'd1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_byte_eight_bits: assert property ($rose(st_r.cs_n) |-> rise_cnt == 3'd0)
      else $error("Frame ended inside a byte");
   a_cs_held_low: assert property (st_r.ph == PH_BIT |-> !st_r.cs_n && !$past(st_r.cs_n))
      else $error("Select rose during transfer");
   a_mosi_stable: assert property ($rose(st_r.sck) |-> $stable(st_r.mosi))
      else $error("Data changed at rising clock");
   a_cs_rise_idle: assert property ($rose(st_r.cs_n)
      |-> !st_r.sck && $past(st_r.ph) == PH_TAIL)
      else $error("Select rose outside tail");
   a_unlock_first: assert property (st_r.step == SQ_MAIN && $past(st_r.step) != SQ_MAIN
      && is_wr(st_r.op) && !(st_r.op == SFC_OP_AUTO_INCREMENT_PROGRAM && st_r.cont)
      |-> $past(st_r.step) == SQ_WEN)
      else $error("Write without unlock");
   a_arm_first: assert property (st_r.step == SQ_MAIN && $past(st_r.step) != SQ_MAIN
      && st_r.op == SFC_OP_STATUS_WRITE_CMD |-> $past(st_r.step) == SQ_ARM)
      else $error("Status write not armed");
   a_poll_after: assert property ($past(st_r.step) == SQ_MAIN && st_r.step != SQ_MAIN
      && is_wr(st_r.op) |-> st_r.step == SQ_POLL)
      else $error("No busy poll after write");
   a_erased_check: assert property ($past(st_r.step) == SQ_CHK && st_r.step == SQ_WEN
      |-> $past(st_r.chk_ff) && !st_r.err)
      else $error("Program of non-erased byte");
   a_idle_deselect: assert property (st_r.step == SQ_IDLE && st_r.ph == PH_IDLE
      |-> ##1 st_r.cs_n && !st_r.sck)
      else $error("Select low while idle");

endmodule : sfc_ctrl

/* File: core/sfc_rxbuf.sv */
// Receive byte buffer with registered read data
`timescale 1ns/1ps
module sfc_rxbuf
   import sfc_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Write side
   input wire logic we,
   input wire logic [SFC_RX_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // Read side
   input wire logic [SFC_RX_AW-1:0] raddr,
   output logic [7:0] rdata
);

   logic [7:0] mem [SFC_RX_DEPTH];

   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule : sfc_rxbuf

/* File: pkg/sfc_pkg.sv */
// Constants, enums and carriers of the serial flash host controller
package sfc_pkg;

   // ==========================================================
   // Timing
   localparam int SFC_CLK_NS = 4;
   localparam int SFC_SCK_HALF_NS = 25;
   localparam int SFC_CS_HIGH_NS = 50;
   localparam logic [3:0] SFC_HALF_CYC =
      4'((SFC_SCK_HALF_NS + SFC_CLK_NS - 1) / SFC_CLK_NS);
   localparam logic [3:0] SFC_GAP_CYC =
      4'((SFC_CS_HIGH_NS + SFC_CLK_NS - 1) / SFC_CLK_NS);

   // ==========================================================
   // Flash opcodes
   localparam logic [7:0] SFC_OP_READ = 8'h03;
   localparam logic [7:0] SFC_OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] SFC_OP_BLOCK_ERASE = 8'h52;
   localparam logic [7:0] SFC_OP_CHIP_ERASE = 8'h60;
   localparam logic [7:0] SFC_OP_BYTE_PROGRAM = 8'h02;
   localparam logic [7:0] SFC_OP_AUTO_INCREMENT_PROGRAM = 8'haf;
   localparam logic [7:0] SFC_OP_STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] SFC_OP_STATUS_WRITE_ARM_CMD = 8'h50;
   localparam logic [7:0] SFC_OP_STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] SFC_OP_WRITE_UNLOCK_CMD = 8'h06;
   localparam logic [7:0] SFC_OP_WRITE_LOCK_CMD = 8'h04;
   localparam logic [7:0] SFC_OP_IDENT_A = 8'h90;
   localparam logic [7:0] SFC_OP_IDENT_B = 8'hab;
   localparam logic [7:0] SFC_ERASED_BYTE = 8'hff;
   localparam int SFC_BUSY_BIT = 0;

   // ==========================================================
   // Register map and fields
   localparam logic [7:0] SFC_REG_CMD = 8'h00;
   localparam logic [7:0] SFC_REG_ADDR = 8'h04;
   localparam logic [7:0] SFC_REG_WDATA = 8'h08;
   localparam logic [7:0] SFC_REG_STATUS = 8'h0c;
   localparam logic [1:0] SFC_RXBUF_PAGE = 2'b01;
   localparam int SFC_RX_AW = 4;
   localparam int SFC_RX_DEPTH = 16;
   localparam logic [4:0] SFC_RX_MAX = 5'd16;
   localparam int SFC_CMD_NRX_LSB = 8;
   localparam int SFC_CMD_CONT_BIT = 16;
   localparam int SFC_ST_ERR_BIT = 1;
   localparam int SFC_ST_FSTAT_LSB = 8;
   localparam int SFC_ST_RXN_LSB = 16;
   localparam logic [1:0] SFC_RESP_OKAY = 2'b00;
   localparam logic [1:0] SFC_RESP_SLVERR = 2'b10;
   localparam logic SFC_RST_CS_N = 1'b1;

   // ==========================================================
   // Enums
   typedef enum logic [2:0] {SQ_IDLE, SQ_CHK, SQ_ARM, SQ_WEN, SQ_MAIN, SQ_POLL} sfc_step_e;
   typedef enum logic [2:0] {PH_IDLE, PH_LEAD, PH_BIT, PH_TAIL, PH_GAP} sfc_ph_e;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } sfc_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sfc_axi_rsp_s;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic mosi;
   } sfc_spi_s;

endpackage : sfc_pkg
